// [rtl/csm_pkg.sv]
// Purpose: Shared constants and types for the converter status and menu controller
// Assumes: 10 MHz pclk, APB register access, 8N1 serial link
// Notes:   Settings image layout is shared with the nonvolatile store
package csm_pkg;
	// Clock and timing
	localparam int CLK_HZ      = 10_000_000;
	localparam int BAUD        = 9600;
	localparam int BAUD_DIV    = (CLK_HZ + BAUD / 2) / BAUD;
	localparam int TMO_S       = 30;
	localparam int TMO_CYC     = TMO_S * CLK_HZ;
	localparam int BOOT_MS     = 500;
	localparam int BOOT_CYC    = BOOT_MS * (CLK_HZ / 1000);
	// APB register offsets
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_FREQ   = 12'h008;
	localparam logic [11:0] REG_GAIN   = 12'h00C;
	// Control fields
	localparam int          CTRL_MUTE_BIT = 0;
	localparam int          CTRL_OPTQ_BIT = 1;
	localparam logic [1:0]  CTRL_RST      = 2'h0;
	// Status fields
	localparam int ST_ALARM_BIT = 0;
	localparam int ST_REM_BIT   = 1;
	localparam int ST_EXT_BIT   = 2;
	localparam int ST_MD_BIT    = 3;
	localparam int ST_MENU_LSB  = 4;
	localparam int ST_ADR_LSB   = 8;
	// Settings image layout
	localparam int NV_FREQ_LSB = 0;
	localparam int NV_GAIN_LSB = 28;
	localparam int NV_REM_BIT  = 34;
	localparam int NV_EXT_BIT  = 35;
	localparam int NV_MD_BIT   = 36;
	localparam int NV_ADR_LSB  = 37;
	localparam int NV_W        = 42;
	// Value limits
	localparam logic [5:0] GAIN_MIN = 6'h1E;
	localparam logic [5:0] GAIN_MAX = 6'h32;
	localparam logic [5:0] ADR_MAX  = 6'h1F;
	// Link characters
	localparam logic [7:0] CH_OPEN  = 8'h7B;
	localparam logic [7:0] CH_CLOSE = 8'h7D;
	localparam logic [7:0] CH_ACK   = 8'h3E;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_S     = 8'h53;
	localparam logic [7:0] CH_C     = 8'h43;
	localparam logic [7:0] CH_ONE   = 8'h31;
	localparam logic [7:0] CH_TWO   = 8'h32;
	typedef enum logic [3:0] {MN_LAMP, MN_VER, MN_NORMAL, MN_FREQ, MN_GAIN, MN_REMOTE,
		MN_EXTREF, MN_LINK, MN_ADDR, MN_SAVEQ, MN_DONE} csm_menu_e;
	typedef enum logic [2:0] {PS_IDLE, PS_AD1, PS_AD2, PS_TYPE, PS_REQ, PS_DATA} csm_parse_e;
	typedef enum logic [1:0] {RK_ACK, RK_S1, RK_S2} csm_reply_e;
endpackage

// [rtl/csm_ctrl.sv]
// Purpose: Serial status responder and front-panel menu controller
// Assumes: Switch inputs are debounced one-cycle pulses; rxd is synchronised here
// Notes:   Contract
// Contract
// RL1 - General status reply carries frequency, gain and alarm characters in braces
// RL2 - Alarm character is one when alarmed, zero when normal
// RL3 - Reference status reply holds one when external reference selected
// RL4 - Two address digits precede the type letter only in multidrop mode
// RL5 - Link runs 9600 baud, start bit, eight data bits, stop bit
// RL6 - Edits take effect only between menu press and confirmed save
// RL7 - About 30 s without switch activity abandons the session
// RL8 - Saved settings kept nonvolatile and restored at power-up
// RL9 - Power-up shows lamp test, version, then frequency and gain
// RL10 - Horizontal switch moves cursor one place left or right
// RL11 - Vertical switch steps digits or toggles on/off functions
// RL12 - Frequency edit reaches synthesizer only after save
// RL13 - Gain edits apply live, stored only after yes
// RL14 - Yes stores, no reverts; next menu press returns to normal
// RL15 - Menu press on return marker or list end goes to save prompt
// RL16 - Menus step frequency, gain, remote, reference, link, address
// RL17 - Gain steps by 1 or 10 dB per cursor digit
// RL18 - Alarm follows any PLL loss of lock
// RL19 - Remote and mute indicators follow their selections
// RL20 - Requests framed by braces with address, type, request, data
// RL21 - Executed command answered with greater-than character
// RL22 - Multidrop frames for another address are ignored silently
`timescale 1ns/1ns
module csm_ctrl #(
	parameter int NPLL     = 2,
	parameter int TMO_CYC  = csm_pkg::TMO_CYC,
	parameter int BOOT_CYC = csm_pkg::BOOT_CYC
) (
	// APB
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Serial link
	input  wire logic                     rxd,
	output logic                          txd,
	// Panel switches
	input  wire logic                     sw_menu,
	input  wire logic                     sw_left,
	input  wire logic                     sw_right,
	input  wire logic                     sw_up,
	input  wire logic                     sw_down,
	// PLL lock detectors
	input  wire logic [NPLL-1:0]          pll_unlock,
	// Nonvolatile settings store
	input  wire logic [csm_pkg::NV_W-1:0] nv_rd_data,
	output logic      [csm_pkg::NV_W-1:0] nv_wr_data,
	output logic                          nv_wr_en,
	// Converter controls
	output logic      [27:0]              freq_bcd,
	output logic      [5:0]               gain_db,
	output logic                          ext_ref_sel,
	output logic                          mute,
	// Panel indicators and display
	output logic                          alarm_led,
	output logic                          alarm_relay,
	output logic                          remote_led,
	output logic                          mute_led,
	output logic      [3:0]               disp_mode,
	output logic      [2:0]               disp_cursor,
	output logic                          save_yes
);
	import csm_pkg::*;

	localparam int TW = $clog2(TMO_CYC + 1);
	localparam int BW = $clog2(BOOT_CYC + 1);
	localparam logic [10:0] DIV_M1  = 11'(BAUD_DIV - 1);
	localparam logic [10:0] HALF_M1 = 11'(BAUD_DIV / 2 - 1);

	generate
		if (TMO_CYC < 2 || BOOT_CYC < 2 || NPLL < 1) begin : g_chk
			$error("csm_ctrl: counts below 2 or no PLL");
		end
	endgenerate

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	csm_menu_e        st;
	csm_parse_e       pst;
	csm_reply_e       rep_kind;
	logic [2:0]       cur;
	logic [1:0]       ctrl_reg;
	logic [6:0][3:0]  s_freq, e_freq;
	logic [5:0]       s_gain, e_gain;
	logic [4:0]       s_adr, e_adr;
	logic             s_rem, s_ext, s_md, e_rem, e_ext, e_md;
	logic             ld_pend, in_sess, commit, tmo_hit, any_sw, solo_v, edit_st;
	logic [TW-1:0]    idle;
	logic [BW-1:0]    boot_cnt;
	logic [5:0]       g_step, g_up;
	logic [4:0]       a_step;
	logic [2:0]       fdig;

	function automatic logic [2:0] ret_pos(input csm_menu_e s);
		case (s)
			MN_FREQ: ret_pos = 3'h7;
			MN_GAIN, MN_ADDR: ret_pos = 3'h2;
			default: ret_pos = 3'h1;
		endcase
	endfunction

	assign in_sess = st inside {MN_FREQ, MN_GAIN, MN_REMOTE, MN_EXTREF, MN_LINK, MN_ADDR, MN_SAVEQ};
	assign edit_st = in_sess && st != MN_SAVEQ;
	assign any_sw  = sw_menu | sw_left | sw_right | sw_up | sw_down;
	assign tmo_hit = in_sess && idle == TW'(TMO_CYC - 1);
	assign commit  = st == MN_SAVEQ && sw_menu && !tmo_hit && save_yes;
	assign solo_v  = !tmo_hit && !sw_menu && !sw_left && !sw_right;
	assign g_step  = (cur == 3'h0) ? 6'h0A : 6'h01;
	assign g_up    = 6'(e_gain + g_step);
	assign a_step  = (cur == 3'h0) ? 5'h0A : 5'h01;
	assign fdig    = 3'(3'h6 - cur);

	// Inactivity timer; a stuck switch keeps the session alive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle <= '0;
		end else if (!in_sess || any_sw) begin
			idle <= '0;
		end else if (!tmo_hit) begin
			idle <= TW'(idle + 1'b1);
		end
	end

	// Menu sequencing and cursor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st       <= MN_LAMP;
			cur      <= 3'h0;
			save_yes <= 1'b1;
			boot_cnt <= '0;
		end else begin
			case (st)
				MN_LAMP, MN_VER: begin
					boot_cnt <= BW'(boot_cnt + 1'b1);
					if (boot_cnt == BW'(BOOT_CYC - 1)) begin
						boot_cnt <= '0;
						st       <= (st == MN_LAMP) ? MN_VER : MN_NORMAL; // RL9
					end
				end
				MN_NORMAL: begin
					if (sw_menu) begin
						st  <= MN_FREQ; // RL6
						cur <= 3'h0;
					end
				end
				MN_SAVEQ: begin
					if (tmo_hit) begin
						st <= MN_NORMAL; // RL7
					end else if (sw_menu) begin
						st <= MN_DONE; // RL14
					end else if (sw_up || sw_down) begin
						save_yes <= !save_yes;
					end
				end
				MN_DONE: begin
					if (sw_menu) begin
						st <= MN_NORMAL; // RL14
					end
				end
				default: begin
					if (tmo_hit) begin
						st <= MN_NORMAL; // RL7
					end else if (sw_menu) begin
						cur      <= 3'h0;
						save_yes <= 1'b1;
						if (cur == ret_pos(st) || st == MN_ADDR) begin
							st <= MN_SAVEQ; // RL15
						end else if (st == MN_EXTREF && !ctrl_reg[CTRL_OPTQ_BIT]) begin
							st <= MN_SAVEQ; // RL16
						end else begin
							st <= csm_menu_e'(st + 4'h1); // RL16
						end
					end else if (sw_left && cur != 3'h0) begin
						cur <= 3'(cur - 3'h1); // RL10
					end else if (sw_right && !sw_left && cur != ret_pos(st)) begin
						cur <= 3'(cur + 3'h1); // RL10
					end
				end
			endcase
		end
	end

	// Pending edits mirror the saved set outside a session, which also reverts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			e_freq <= '0;
			e_gain <= GAIN_MIN;
			e_adr  <= 5'h00;
			{e_rem, e_ext, e_md} <= 3'h0;
		end else if (!in_sess) begin
			e_freq <= s_freq; // RL14
			e_gain <= s_gain;
			e_adr  <= s_adr;
			{e_rem, e_ext, e_md} <= {s_rem, s_ext, s_md};
		end else if (edit_st && solo_v && (sw_up || sw_down) && cur != ret_pos(st)) begin
			case (st)
				MN_FREQ: begin
					if (sw_up) begin
						e_freq[fdig] <= (e_freq[fdig] == 4'h9) ? 4'h0 : 4'(e_freq[fdig] + 4'h1); // RL11
					end else begin
						e_freq[fdig] <= (e_freq[fdig] == 4'h0) ? 4'h9 : 4'(e_freq[fdig] - 4'h1); // RL11
					end
				end
				MN_GAIN: begin
					if (sw_up && g_up <= GAIN_MAX) begin
						e_gain <= g_up; // RL17
					end else if (!sw_up && e_gain >= 6'(GAIN_MIN + g_step)) begin
						e_gain <= 6'(e_gain - g_step); // RL17
					end
				end
				MN_REMOTE: e_rem <= !e_rem; // RL11
				MN_EXTREF: e_ext <= !e_ext;
				MN_LINK:   e_md  <= !e_md;
				MN_ADDR: begin
					if (sw_up && ({1'b0, e_adr} + {1'b0, a_step}) <= ADR_MAX) begin
						e_adr <= 5'(e_adr + a_step);
					end else if (!sw_up && e_adr >= a_step) begin
						e_adr <= 5'(e_adr - a_step);
					end
				end
				default: e_gain <= e_gain;
			endcase
		end
	end

	// Saved settings: restored from the store once after reset, replaced on save
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ld_pend <= 1'b1;
			s_freq  <= '0;
			s_gain  <= GAIN_MIN;
			s_adr   <= 5'h00;
			{s_rem, s_ext, s_md} <= 3'h0;
			nv_wr_en   <= 1'b0;
			nv_wr_data <= '0;
		end else begin
			nv_wr_en <= commit; // RL8
			if (ld_pend) begin
				ld_pend <= 1'b0;
				s_freq  <= nv_rd_data[NV_FREQ_LSB +: 28]; // RL8
				s_gain  <= nv_rd_data[NV_GAIN_LSB +: 6];
				s_adr   <= nv_rd_data[NV_ADR_LSB +: 5];
				s_rem   <= nv_rd_data[NV_REM_BIT];
				s_ext   <= nv_rd_data[NV_EXT_BIT];
				s_md    <= nv_rd_data[NV_MD_BIT];
			end else if (commit) begin
				s_freq <= e_freq; // RL12
				s_gain <= e_gain; // RL13
				s_adr  <= e_adr;
				{s_rem, s_ext, s_md} <= {e_rem, e_ext, e_md};
				nv_wr_data <= {e_adr, e_md, e_ext, e_rem, e_gain, e_freq};
			end
		end
	end

	// Converter controls and indicators
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_bcd    <= '0;
			gain_db     <= GAIN_MIN;
			ext_ref_sel <= 1'b0;
			mute        <= 1'b0;
			alarm_led   <= 1'b0;
			alarm_relay <= 1'b0;
			remote_led  <= 1'b0;
			mute_led    <= 1'b0;
			disp_mode   <= 4'h0;
			disp_cursor <= 3'h0;
		end else begin
			freq_bcd    <= s_freq; // RL12
			gain_db     <= in_sess ? e_gain : s_gain; // RL13
			ext_ref_sel <= s_ext;
			mute        <= ctrl_reg[CTRL_MUTE_BIT];
			alarm_led   <= |pll_unlock; // RL18
			alarm_relay <= |pll_unlock; // RL18
			remote_led  <= s_rem; // RL19
			mute_led    <= ctrl_reg[CTRL_MUTE_BIT]; // RL19
			disp_mode   <= st;
			disp_cursor <= cur;
		end
	end

	// Serial receiver
	logic       rx_s1, rx_s2, rx_busy, rx_valid;
	logic [10:0] rx_cnt;
	logic [3:0] rx_bit;
	logic [7:0] rx_sh;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{rx_s1, rx_s2} <= 2'h3;
			rx_busy  <= 1'b0;
			rx_valid <= 1'b0;
			rx_cnt   <= 11'h000;
			rx_bit   <= 4'h0;
			rx_sh    <= 8'h00;
		end else begin
			rx_s1    <= rxd;
			rx_s2    <= rx_s1;
			rx_valid <= 1'b0;
			if (!rx_busy) begin
				if (!rx_s2) begin
					rx_busy <= 1'b1;
					rx_cnt  <= HALF_M1; // RL5
					rx_bit  <= 4'h0;
				end
			end else if (rx_cnt != 11'h000) begin
				rx_cnt <= 11'(rx_cnt - 11'h001);
			end else begin
				rx_cnt <= DIV_M1;
				rx_bit <= 4'(rx_bit + 4'h1);
				if (rx_bit == 4'h0 && rx_s2) begin
					rx_busy <= 1'b0;
				end else if (rx_bit == 4'h9) begin
					rx_busy  <= 1'b0;
					rx_valid <= rx_s2; // RL5
				end else if (rx_bit != 4'h0) begin
					rx_sh <= {rx_s2, rx_sh[7:1]};
				end
			end
		end
	end

	// Request parser
	logic [3:0] p_hi, p_lo;
	logic [7:0] p_type, p_req;
	logic       addr_ok, rep_go, rep_act, tx_busy, fr_close;
	csm_reply_e go_kind;
	assign addr_ok  = !s_md || ({4'h0, p_hi} * 8'h0A + {4'h0, p_lo}) == {3'h0, s_adr};
	assign fr_close = rx_valid && rx_sh == CH_CLOSE && pst == PS_DATA;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pst     <= PS_IDLE;
			p_hi    <= 4'h0;
			p_lo    <= 4'h0;
			p_type  <= 8'h00;
			p_req   <= 8'h00;
			rep_go  <= 1'b0;
			go_kind <= RK_ACK;
		end else begin
			rep_go <= 1'b0;
			if (rx_valid && rx_sh == CH_OPEN) begin
				pst <= s_md ? PS_AD1 : PS_TYPE; // RL4
			end else if (rx_valid) begin
				case (pst)
					PS_AD1: begin
						p_hi <= rx_sh[3:0]; // RL4
						pst  <= PS_AD2;
					end
					PS_AD2: begin
						p_lo <= rx_sh[3:0];
						pst  <= PS_TYPE;
					end
					PS_TYPE: begin
						p_type <= rx_sh; // RL20
						pst    <= PS_REQ;
					end
					PS_REQ: begin
						p_req <= rx_sh;
						pst   <= (rx_sh == CH_CLOSE) ? PS_IDLE : PS_DATA;
					end
					PS_DATA: begin
						if (rx_sh == CH_CLOSE) begin
							pst <= PS_IDLE; // RL20
							if (addr_ok && !rep_act && !tx_busy) begin // RL22
								if (p_type == CH_C) begin
									rep_go  <= 1'b1;
									go_kind <= RK_ACK; // RL21
								end else if (p_type == CH_S && p_req == CH_ONE) begin
									rep_go  <= 1'b1;
									go_kind <= RK_S1;
								end else if (p_type == CH_S && p_req == CH_TWO) begin
									rep_go  <= 1'b1;
									go_kind <= RK_S2;
								end
							end
						end
					end
					default: pst <= PS_IDLE;
				endcase
			end
		end
	end

	// Reply character selection
	logic [3:0] rep_idx, rep_last, fsel;
	logic [7:0] tx_ch;
	logic [5:0] g_t, g_u;
	assign g_t  = gain_db / 6'h0A;
	assign g_u  = 6'(gain_db - 6'(g_t * 6'h0A));
	assign fsel = 4'(4'h9 - rep_idx);
	always_comb begin
		tx_ch = CH_CLOSE;
		if (rep_kind == RK_ACK) begin
			tx_ch = CH_ACK; // RL21
		end else if (rep_idx == 4'h0) begin
			tx_ch = CH_OPEN;
		end else if (rep_idx == 4'h1) begin
			tx_ch = CH_S;
		end else if (rep_idx == 4'h2) begin
			tx_ch = (rep_kind == RK_S1) ? CH_ONE : CH_TWO;
		end else if (rep_kind == RK_S2) begin
			tx_ch = (rep_idx == 4'h3) ? CH_ZERO | {7'h00, ext_ref_sel} : CH_CLOSE; // RL3
		end else if (rep_idx <= 4'h9) begin
			tx_ch = CH_ZERO | {4'h0, s_freq[fsel[2:0]]}; // RL1
		end else if (rep_idx == 4'hA) begin
			tx_ch = CH_ZERO | {2'h0, g_t};
		end else if (rep_idx == 4'hB) begin
			tx_ch = CH_ZERO | {2'h0, g_u};
		end else if (rep_idx == 4'hC) begin
			tx_ch = CH_ZERO;
		end else if (rep_idx == 4'hD) begin
			tx_ch = CH_ZERO | {7'h00, alarm_led}; // RL2
		end
	end

	// Reply sequencing and serial transmitter
	logic [10:0] tx_cnt;
	logic [3:0]  tx_bit;
	logic [8:0]  tx_sh;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rep_act  <= 1'b0;
			rep_kind <= RK_ACK;
			rep_idx  <= 4'h0;
			rep_last <= 4'h0;
			tx_busy  <= 1'b0;
			tx_cnt   <= 11'h000;
			tx_bit   <= 4'h0;
			tx_sh    <= 9'h1FF;
			txd      <= 1'b1;
		end else begin
			if (rep_go) begin
				rep_act  <= 1'b1;
				rep_kind <= go_kind;
				rep_idx  <= 4'h0;
				rep_last <= (go_kind == RK_S1) ? 4'hE : (go_kind == RK_S2) ? 4'h4 : 4'h0; // RL1
			end else if (rep_act && !tx_busy) begin
				tx_sh   <= {1'b1, tx_ch};
				txd     <= 1'b0; // RL5
				tx_busy <= 1'b1;
				tx_bit  <= 4'h0;
				tx_cnt  <= DIV_M1;
				rep_idx <= 4'(rep_idx + 4'h1);
				rep_act <= rep_idx != rep_last;
			end
			if (tx_busy) begin
				if (tx_cnt != 11'h000) begin
					tx_cnt <= 11'(tx_cnt - 11'h001);
				end else if (tx_bit == 4'h9) begin
					tx_busy <= 1'b0;
				end else begin
					txd    <= tx_sh[0]; // RL5
					tx_sh  <= {1'b1, tx_sh[8:1]};
					tx_bit <= 4'(tx_bit + 4'h1);
					tx_cnt <= DIV_M1;
				end
			end
		end
	end

	// APB slave, one setup and one access cycle
	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
			REG_CTRL:   rd_mux = {30'h0, ctrl_reg};
			REG_STATUS: begin
				rd_mux[ST_ALARM_BIT]         = alarm_led;
				rd_mux[ST_REM_BIT]           = s_rem;
				rd_mux[ST_EXT_BIT]           = s_ext;
				rd_mux[ST_MD_BIT]            = s_md;
				rd_mux[ST_MENU_LSB +: 4]     = st;
				rd_mux[ST_ADR_LSB +: 5]      = s_adr;
			end
			REG_FREQ:   rd_mux = {4'h0, s_freq};
			REG_GAIN:   rd_mux = {26'h0, gain_db};
			default:    rd_hit = 1'b0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
			ctrl_reg <= CTRL_RST;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !rd_hit;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
			if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
				ctrl_reg <= pwdata[1:0];
			end
		end
	end

	sequence s_gain_up;
		st == MN_GAIN && cur == 3'h1 && sw_up && solo_v && e_gain < GAIN_MAX;
	endsequence
	sequence s_cmd_close;
		fr_close && p_type == CH_C && addr_ok && !rep_act && !tx_busy;
	endsequence

	a_alarm_follow: assert property (|pll_unlock |=> alarm_led && alarm_relay) // RL18
		else $error("alarm not raised on PLL unlock");
	a_freq_hold: assert property (in_sess |=> $stable(freq_bcd)) // RL12
		else $error("frequency changed during session");
	a_gain_live: assert property (s_gain_up |=> ##1 gain_db == 6'($past(e_gain, 2) + 6'h01)) // RL13
		else $error("gain edit not applied live");
	a_tmo_exit: assert property (tmo_hit |=> st == MN_NORMAL ##1 gain_db == s_gain) // RL7
		else $error("timeout did not abandon session");
	a_cur_right: assert property (edit_st && sw_right && !sw_left && !sw_menu && !tmo_hit
		&& cur != ret_pos(st) |=> cur == 3'($past(cur) + 3'h1)) // RL10
		else $error("cursor did not move right");
	a_rem_toggle: assert property (st == MN_REMOTE && cur == 3'h0 && solo_v && (sw_up || sw_down)
		|=> e_rem != $past(e_rem)) // RL11
		else $error("remote selection not toggled");
	// Parser pulse, then reply start, then start bit: one register stage each
	a_cmd_ack: assert property (s_cmd_close |=> ##1 rep_act && rep_kind == RK_ACK ##1 tx_busy && !txd) // RL21
		else $error("command not acknowledged");
	a_start_bit: assert property ($rose(tx_busy) |-> !txd [*8]) // RL5
		else $error("start bit too short");
	a_addr_drop: assert property (fr_close && s_md && !addr_ok && !rep_act |=> !rep_act [*2]) // RL22
		else $error("frame for other address answered");
	a_save_store: assert property (commit |=> nv_wr_en && s_gain == $past(e_gain)) // RL14
		else $error("save did not store settings");
endmodule

// [test/csm_host.sv]
// Purpose: Remote host model on the serial link
// Assumes: 8N1 framing, idle high
// Notes:   Received reply characters are queued in rx_q
`timescale 1ns/1ns
module csm_host #(
	parameter int BIT_CYC = 1042
) (
	input  wire logic pclk,
	input  wire logic txd,
	output logic      rxd
);
	logic [7:0] rx_q[$];
	initial rxd = 1'b1;
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge pclk);
			rxd <= fr[i];
			repeat (BIT_CYC - 1) @(posedge pclk);
		end
	endtask
	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++) send_byte(s[i]);
	endtask
	// Mid-bit sampling tolerates the reply's edge skew
	initial forever begin : rx_loop
		logic [7:0] b;
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge pclk);
			b[i] = txd;
		end
		repeat (BIT_CYC) @(posedge pclk);
		rx_q.push_back(b);
	end
endmodule

// [test/csm_ctrl_tb.sv]
// Purpose: Self-checking bench for the status and menu controller
// Assumes: Short timeout and boot counts
// Notes:   Only the short reference query crosses the link, to bound run time
`timescale 1ns/1ns
module csm_ctrl_tb;
	import csm_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nv_wr_en, pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rv;
	logic [4:0] sw = 0;
	logic [1:0] pll = 0;
	logic [41:0] nv_in = {5'h00, 1'b0, 1'b1, 1'b0, 6'h28, 28'h3750125}, nv_out;
	string exp_r = "{S21}";
	logic [27:0] freq;
	logic [5:0] gain;
	logic [3:0] dm;
	logic [2:0] cur;
	logic txd, rxd, ext, mute, al, alr, rl, ml, sy, er;
	int fail_count = 0, total_checks = 0;
	logic [11:0] ra[5] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
	logic [31:0] rd[5] = '{32'h0, 32'h24, 32'h03750125, 32'h28, 32'h0};
	always #50 pclk = ~pclk;
	// Store model: captures the image on each write pulse and holds it afterwards
	always @(posedge pclk) if (nv_wr_en) nv_in <= nv_out;
	csm_ctrl #(.TMO_CYC(200), .BOOT_CYC(4)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.sw_menu(sw[0]), .sw_left(sw[1]), .sw_right(sw[2]), .sw_up(sw[3]), .sw_down(sw[4]),
		.pll_unlock(pll), .nv_rd_data(nv_in), .nv_wr_data(nv_out), .nv_wr_en(nv_wr_en),
		.freq_bcd(freq), .gain_db(gain), .ext_ref_sel(ext), .mute(mute), .alarm_led(al),
		.alarm_relay(alr), .remote_led(rl), .mute_led(ml), .disp_mode(dm),
		.disp_cursor(cur), .save_yes(sy));
	csm_host host (.pclk(pclk), .txd(txd), .rxd(rxd));
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(n < 20, "apb hang");
		rv = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic press(input int k);
		@(posedge pclk);
		sw[k] <= 1'b1;
		@(posedge pclk);
		sw <= 5'h00;
		repeat (3) @(posedge pclk);
	endtask
	initial begin
		repeat (99000) @(posedge pclk);
		fail_count++;
		test_done();
	end
	initial begin
		int n;
		repeat (5) @(posedge pclk);
		chk(txd === 1'b1 && dm === 4'h0 && gain === 6'h1E, "reset values");
		presetn <= 1'b1;
		chk(dm === 4'h0, "lamp test first");
		for (n = 0; n < 40 && dm !== 4'h2; n++) @(posedge pclk);
		chk(dm === 4'h2 && freq === 28'h3750125 && gain === 6'h28, "boot restore");
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ra[i], 32'h0);
			chk(rv === rd[i] && er === (i == 4), "register read");
		end
		apb(1'b1, 12'h000, 32'h1);
		repeat (2) @(posedge pclk);
		chk(mute === 1'b1 && ml === 1'b1, "mute led");
		pll <= 2'h2;
		repeat (2) @(posedge pclk);
		chk(al === 1'b1 && alr === 1'b1, "alarm on unlock");
		press(0);
		chk(dm === 4'h3 && cur === 3'h0, "freq menu");
		press(2);
		chk(cur === 3'h1, "cursor right");
		press(1);
		chk(cur === 3'h0, "cursor left");
		press(3);
		chk(freq === 28'h3750125, "freq not applied");
		press(0);
		chk(dm === 4'h4, "gain menu");
		press(3);
		chk(gain === 6'h32, "gain live tens");
		press(2);
		press(4);
		chk(gain === 6'h31, "gain unit step");
		press(0);
		chk(dm === 4'h5 && cur === 3'h0, "remote menu");
		press(3);
		press(2);
		chk(rl === 1'b0 && cur === 3'h1, "remote not applied early");
		press(0);
		chk(dm === 4'h9 && nv_wr_en === 1'b0, "save prompt");
		n = sy;
		press(4);
		chk(sy === ~n[0], "toggle choice");
		if (sy !== 1'b1) press(3);
		press(0);
		chk(dm === 4'hA && nv_out[33:28] === 6'h31 && nv_out[27:0] === 28'h4750125
			&& nv_out[34] === 1'b1 && rl === 1'b1, "saved");
		press(0);
		chk(dm === 4'h2, "back to normal");
		press(0);
		press(0);
		press(4);
		chk(gain === 6'h27, "live edit");
		repeat (260) @(posedge pclk);
		chk(dm === 4'h2 && gain === 6'h31, "timeout revert");
		// Power cycle: settings must come back from the store image
		pll <= 2'h0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (n = 0; n < 40 && dm !== 4'h2; n++) @(posedge pclk);
		chk(dm === 4'h2 && freq === 28'h4750125 && gain === 6'h31 && rl === 1'b1
			&& al === 1'b0, "restore after reset");
		host.send_str("{S2}");
		for (n = 0; n < 60000 && host.rx_q.size() < 5; n++) @(posedge pclk);
		chk(host.rx_q.size() == 5, "reply length");
		for (int i = 0; i < host.rx_q.size() && i < 5; i++)
			chk(host.rx_q[i] === exp_r[i], "reply char");
		test_done();
	end
endmodule
